// File: verilog/ddfd_pkg.sv
package ddfd_pkg;

  // ==========================================================
  // second doubleword field positions; ALIGN_BIT is a first doubleword bit
  localparam int REGION_LSB        = 16;
  localparam int DW1_ZERO_BIT      = 15;
  localparam int SRC1_TYPE_LSB     = 12;
  localparam int SRC1_FILE_LSB     = 10;
  localparam int SRC0_TYPE_LSB     = 7;
  localparam int SRC0_FILE_LSB     = 5;
  localparam int DST_TYPE_LSB      = 2;
  localparam int DST_FILE_LSB      = 0;
  localparam int ALIGN_BIT         = 8;

  // ==========================================================
  // destination region subfields (relative to region)
  localparam int RGN_ADDR_MODE_BIT = 15;
  localparam int RGN_STRIDE_LSB    = 13;
  localparam int RGN_REGNUM_LSB    = 5;
  localparam int RGN_HALF_BIT      = 4;
  localparam int RGN_SUBREG_LSB    = 0;
  localparam int RGN_CHANEN_LSB    = 0;
  localparam int RGN_ASUB_LSB      = 10;
  localparam int RGN_OFFSET_LSB    = 4;

  // ==========================================================
  // register map and bus answers
  localparam logic [7:0] ADDR_CTRL         = 8'h00;
  localparam logic [7:0] ADDR_STATUS       = 8'h04;
  localparam logic [7:0] ADDR_LAST_ILLEGAL = 8'h08;
  localparam logic       CTRL_ENABLE_RESET = 1'h1;
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    NT_UDWORD      = 4'h0,
    NT_SDWORD      = 4'h1,
    NT_UWORD       = 4'h2,
    NT_SWORD       = 4'h3,
    NT_UBYTE       = 4'h4,
    NT_SBYTE       = 4'h5,
    NT_DOUBLE      = 4'h6,
    NT_FLOAT       = 4'h7,
    NT_PACK_UHALF  = 4'h8,
    NT_PACK_RFLOAT = 4'h9,
    NT_PACK_SHALF  = 4'ha
  } ddfd_numeric_type_type;

  typedef enum logic [1:0] {
    RF_ARCH      = 2'h0,
    RF_GENERAL   = 2'h1,
    RF_RESERVED  = 2'h2,
    RF_IMMEDIATE = 2'h3
  } ddfd_register_file_type;

  typedef enum logic [1:0] {
    LY_DIRECT_A16   = 2'h0,
    LY_DIRECT_A1    = 2'h1,
    LY_INDIRECT_A16 = 2'h2,
    LY_INDIRECT_A1  = 2'h3
  } ddfd_layout_type;

  // ==========================================================
  // shared decoders
  function automatic ddfd_numeric_type_type ddfd_decode_type(input logic [2:0] code, input logic immediate_operand_space);
    ddfd_numeric_type_type t;
    t = ddfd_numeric_type_type'({1'h0, code});
    if (immediate_operand_space && code == 3'h4) begin
      t = NT_PACK_UHALF;
    end else if (immediate_operand_space && code == 3'h5) begin
      t = NT_PACK_RFLOAT;
    end else if (immediate_operand_space && code == 3'h6) begin
      t = NT_PACK_SHALF;
    end
    return t;
  endfunction

  function automatic ddfd_register_file_type ddfd_decode_file(input logic [1:0] code, input logic imm_ok);
    ddfd_register_file_type f;
    f = ddfd_register_file_type'(code);
    if (code == 2'h3 && !imm_ok) begin
      f = RF_RESERVED;
    end
    return f;
  endfunction

endpackage

// File: verilog/ddfd_operand_decode.sv
`timescale 1ns/1ps
module ddfd_operand_decode
  import ddfd_pkg::*;
(
  input  wire logic [2:0]        type_code,
  input  wire logic [1:0]        file_code,
  input  wire logic              imm_allowed,
  output ddfd_numeric_type_type  numeric_type,
  output ddfd_register_file_type register_file,
  output logic                   file_reserved
);

  // ==========================================================
  // file then type
  // file code map
  assign register_file = ddfd_decode_file(file_code, imm_allowed);
  assign numeric_type  = ddfd_decode_type(type_code, register_file == RF_IMMEDIATE);
  assign file_reserved = register_file == RF_RESERVED;

endmodule // ddfd_operand_decode

// File: verilog/ddfd_region_decode.sv
`timescale 1ns/1ps
module ddfd_region_decode
  import ddfd_pkg::*;
(
  input  wire logic [15:0] region,
  input  wire logic        sixteen_byte_aligned_operands,
  input  wire logic        is_send,
  output ddfd_layout_type  layout,
  output logic             cur_addr_mode,
  output logic             post_addr_mode,
  output logic [7:0]       regnum,
  output logic [4:0]       subreg,
  output logic [3:0]       chanen,
  output logic [1:0]       stride,
  output logic [2:0]       asub,
  output logic [9:0]       offset,
  output logic             zero_bad
);

  // ==========================================================
  // layout select and fields
  always_comb begin
    layout         = ddfd_layout_type'({region[RGN_ADDR_MODE_BIT], ~sixteen_byte_aligned_operands});
    post_addr_mode = region[RGN_ADDR_MODE_BIT];
    cur_addr_mode  = is_send ? 1'h0 : region[RGN_ADDR_MODE_BIT];
    regnum         = 8'h00;
    subreg         = 5'h00;
    chanen         = 4'hf;
    stride         = 2'h0;
    asub           = 3'h0;
    offset         = 10'h000;
    zero_bad       = 1'h0;
    unique case (layout)
      LY_DIRECT_A16: begin
        // stride 01 from producer is legal
        zero_bad = region[RGN_STRIDE_LSB + 1];
        regnum   = region[RGN_REGNUM_LSB +: 8];
        subreg   = {region[RGN_HALF_BIT], 4'h0};
        chanen   = region[RGN_CHANEN_LSB +: 4];
      end
      LY_DIRECT_A1: begin
        stride = region[RGN_STRIDE_LSB +: 2];
        regnum = region[RGN_REGNUM_LSB +: 8];
        subreg = region[RGN_SUBREG_LSB +: 5];
      end
      LY_INDIRECT_A16: begin
        zero_bad = region[RGN_STRIDE_LSB + 1];
        asub     = region[RGN_ASUB_LSB +: 3];
        offset   = {region[RGN_OFFSET_LSB +: 6], 4'h0};
        chanen   = region[RGN_CHANEN_LSB +: 4];
      end
      LY_INDIRECT_A1: begin
        stride = region[RGN_STRIDE_LSB +: 2];
      end
    endcase
  end

endmodule // ddfd_region_decode

// File: verilog/ddfd_top.sv
`timescale 1ns/1ps
// Summary of operation
// - upper half is destination region
// - source1 type table chosen by register file
// - register table: dword, word, byte, double, float
// - immediate table swaps in packed vector codes
// - source1 file: arch, general, reserved, immediate
// - source0 fields decoded like source1 fields
// - destination type uses register table
// - bits taken literally, never converted
// - destination file: arch, general, two reserved
// - direct sixteen-byte region layout
// - direct byte-aligned region layout
// - indirect sixteen-byte region layout
// - send current destination always direct
// - send fields split current and post
// - first doubleword bit 8 picks alignment
module ddfd_top
  import ddfd_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              instr_valid,
  input  wire logic [31:0]       instr_dword0,
  input  wire logic [31:0]       instr_dword1,
  input  wire logic              instr_is_send,
  output logic                   decode_valid,
  output ddfd_numeric_type_type  source1_numeric_type,
  output ddfd_register_file_type source1_register_file,
  output ddfd_numeric_type_type  source0_numeric_type,
  output ddfd_register_file_type source0_register_file,
  output ddfd_numeric_type_type  dest_numeric_type,
  output ddfd_register_file_type dest_register_file,
  output ddfd_layout_type        dest_layout,
  output logic                   current_destination_addressing,
  output logic                   dest_addressing_select,
  output logic [7:0]             dest_register_number,
  output logic [4:0]             dest_subregister_number,
  output logic [3:0]             dest_channel_write_enables,
  output logic [1:0]             dest_horizontal_stride,
  output logic [2:0]             dest_address_subregister,
  output logic [9:0]             dest_immediate_offset,
  output logic                   decode_illegal
);

  // ==========================================================
  // state
  typedef struct packed {
    logic                   ctrl_enable;
    logic                   illegal_seen;
    logic [15:0]            decode_count;
    logic [31:0]            last_illegal;
    logic                   aw_got;
    logic [ADDR_W-1:0]      aw_addr;
    logic                   w_got;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic                   out_valid;
    ddfd_numeric_type_type  src1_type;
    ddfd_register_file_type src1_file;
    ddfd_numeric_type_type  src0_type;
    ddfd_register_file_type src0_file;
    ddfd_numeric_type_type  dst_type;
    ddfd_register_file_type dst_file;
    ddfd_layout_type        layout;
    logic                   cur_addr_mode;
    logic                   post_addr_mode;
    logic [7:0]             regnum;
    logic [4:0]             subreg;
    logic [3:0]             chanen;
    logic [1:0]             stride;
    logic [2:0]             asub;
    logic [9:0]             offset;
    logic                   illegal;
  } ddfd_state_type;

  ddfd_state_type s;
  ddfd_state_type next_s;

  // ==========================================================
  // address map
  function automatic logic [1:0] map_select(input logic [ADDR_W-1:0] a);
    logic [1:0] sel;
    sel = 2'h3;
    if (a == ADDR_W'(ADDR_CTRL)) begin
      sel = 2'h0;
    end else if (a == ADDR_W'(ADDR_STATUS)) begin
      sel = 2'h1;
    end else if (a == ADDR_W'(ADDR_LAST_ILLEGAL)) begin
      sel = 2'h2;
    end
    return sel;
  endfunction

  // ==========================================================
  // field slicing
  logic [2:0]  src1_code;
  logic [1:0]  src1_fcode;
  logic [2:0]  src0_code;
  logic [1:0]  src0_fcode;
  logic [2:0]  dst_code;
  logic [1:0]  dst_fcode;
  logic [15:0] region;
  logic        sixteen_byte_aligned_operands;
  logic        take;

  assign region     = instr_dword1[REGION_LSB +: 16];
  assign src1_code  = instr_dword1[SRC1_TYPE_LSB +: 3];
  assign src1_fcode = instr_dword1[SRC1_FILE_LSB +: 2];
  assign src0_code  = instr_dword1[SRC0_TYPE_LSB +: 3];
  assign src0_fcode = instr_dword1[SRC0_FILE_LSB +: 2];
  assign dst_code   = instr_dword1[DST_TYPE_LSB +: 3];
  assign dst_fcode  = instr_dword1[DST_FILE_LSB +: 2];
  assign sixteen_byte_aligned_operands    = instr_dword0[ALIGN_BIT];
  assign take       = instr_valid & s.ctrl_enable;

  // ==========================================================
  // operand decoders
  ddfd_numeric_type_type  d_src1_type;
  ddfd_register_file_type d_src1_file;
  logic                   d_src1_bad;
  ddfd_numeric_type_type  d_src0_type;
  ddfd_register_file_type d_src0_file;
  logic                   d_src0_bad;
  ddfd_numeric_type_type  d_dst_type;
  ddfd_register_file_type d_dst_file;
  logic                   d_dst_bad;

  ddfd_operand_decode u_src1 (
    .type_code     (src1_code),
    .file_code     (src1_fcode),
    .imm_allowed   (1'h1),
    .numeric_type  (d_src1_type),
    .register_file (d_src1_file),
    .file_reserved (d_src1_bad)
  );

  ddfd_operand_decode u_src0 (
    .type_code     (src0_code),
    .file_code     (src0_fcode),
    .imm_allowed   (1'h1),
    .numeric_type  (d_src0_type),
    .register_file (d_src0_file),
    .file_reserved (d_src0_bad)
  );

  ddfd_operand_decode u_dst (
    .type_code     (dst_code),
    .file_code     (dst_fcode),
    .imm_allowed   (1'h0),
    .numeric_type  (d_dst_type),
    .register_file (d_dst_file),
    .file_reserved (d_dst_bad)
  );

  // ==========================================================
  // region decoder
  ddfd_layout_type d_layout;
  logic            d_cur_mode;
  logic            d_post_mode;
  logic [7:0]      d_regnum;
  logic [4:0]      d_subreg;
  logic [3:0]      d_chanen;
  logic [1:0]      d_stride;
  logic [2:0]      d_asub;
  logic [9:0]      d_offset;
  logic            d_zero_bad;

  ddfd_region_decode u_region (
    .region         (region),
    .sixteen_byte_aligned_operands        (sixteen_byte_aligned_operands),
    .is_send        (instr_is_send),
    .layout         (d_layout),
    .cur_addr_mode  (d_cur_mode),
    .post_addr_mode (d_post_mode),
    .regnum         (d_regnum),
    .subreg         (d_subreg),
    .chanen         (d_chanen),
    .stride         (d_stride),
    .asub           (d_asub),
    .offset         (d_offset),
    .zero_bad       (d_zero_bad)
  );

  logic d_illegal;
  assign d_illegal = d_src1_bad | d_src0_bad | d_dst_bad | d_zero_bad | instr_dword1[DW1_ZERO_BIT];

  // ==========================================================
  // next state
  logic wr_fire;
  logic ar_fire;

  always_comb begin
    next_s  = s;
    wr_fire = s.aw_got & s.w_got & ~s.bvalid;
    ar_fire = s_axi_arvalid & ~s.rvalid;
    // bus write channels, either order
    if (s_axi_awvalid && !s.aw_got && !s.bvalid) begin
      next_s.aw_got  = 1'h1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_got && !s.bvalid) begin
      next_s.w_got  = 1'h1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'h0;
    end
    if (wr_fire) begin
      next_s.aw_got = 1'h0;
      next_s.w_got  = 1'h0;
      next_s.bvalid = 1'h1;
      next_s.bresp  = RESP_OKAY;
      unique case (map_select(s.aw_addr))
        2'h0: begin
          if (s.w_strb[0]) begin
            next_s.ctrl_enable = s.w_data[0];
          end
        end
        2'h1: begin
          if (s.w_strb[0] && s.w_data[0]) begin
            next_s.illegal_seen = 1'h0;
          end
        end
        2'h2: begin
        end
        2'h3: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end
    // bus read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'h0;
    end
    if (ar_fire) begin
      next_s.rvalid = 1'h1;
      next_s.rresp  = RESP_OKAY;
      unique case (map_select(s_axi_araddr))
        2'h0: next_s.rdata = {31'h0, s.ctrl_enable};
        2'h1: next_s.rdata = {s.decode_count, 15'h0, s.illegal_seen};
        2'h2: next_s.rdata = s.last_illegal;
        2'h3: begin
          next_s.rdata = 32'h0;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    // decode stage
    next_s.out_valid = take;
    if (take) begin
      next_s.src1_type      = d_src1_type;
      next_s.src1_file      = d_src1_file;
      next_s.src0_type      = d_src0_type;
      next_s.src0_file      = d_src0_file;
      next_s.dst_type       = d_dst_type;
      next_s.dst_file       = d_dst_file;
      next_s.layout         = d_layout;
      next_s.cur_addr_mode  = d_cur_mode;
      next_s.post_addr_mode = d_post_mode;
      next_s.regnum         = d_regnum;
      next_s.subreg         = d_subreg;
      next_s.chanen         = d_chanen;
      next_s.stride         = d_stride;
      next_s.asub           = d_asub;
      next_s.offset         = d_offset;
      next_s.illegal        = d_illegal;
      next_s.decode_count   = s.decode_count + 16'h1;
      if (d_illegal) begin
        next_s.illegal_seen = 1'h1;
        next_s.last_illegal = instr_dword1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s             <= '0;
      s.ctrl_enable <= CTRL_ENABLE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready                  = ~s.aw_got & ~s.bvalid;
  assign s_axi_wready                   = ~s.w_got & ~s.bvalid;
  assign s_axi_bvalid                   = s.bvalid;
  assign s_axi_bresp                    = s.bresp;
  assign s_axi_arready                  = ~s.rvalid;
  assign s_axi_rvalid                   = s.rvalid;
  assign s_axi_rdata                    = s.rdata;
  assign s_axi_rresp                    = s.rresp;
  assign decode_valid                   = s.out_valid;
  assign source1_numeric_type           = s.src1_type;
  assign source1_register_file          = s.src1_file;
  assign source0_numeric_type           = s.src0_type;
  assign source0_register_file          = s.src0_file;
  assign dest_numeric_type              = s.dst_type;
  assign dest_register_file             = s.dst_file;
  assign dest_layout                    = s.layout;
  assign current_destination_addressing = s.cur_addr_mode;
  assign dest_addressing_select         = s.post_addr_mode;
  assign dest_register_number           = s.regnum;
  assign dest_subregister_number        = s.subreg;
  assign dest_channel_write_enables     = s.chanen;
  assign dest_horizontal_stride         = s.stride;
  assign dest_address_subregister       = s.asub;
  assign dest_immediate_offset          = s.offset;
  assign decode_illegal                 = s.illegal;

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_src1_reg_type: assert property (
    take && src1_fcode != 2'h3 |=> source1_numeric_type == ddfd_numeric_type_type'({1'h0, $past(src1_code)}))
    else $error("source1 register type wrong");

  a_src1_imm_type: assert property (
    take && src1_fcode == 2'h3 && src1_code == 3'h6 |=> source1_numeric_type == NT_PACK_SHALF)
    else $error("source1 immediate type wrong");

  a_src1_file_code: assert property (
    take |=> source1_register_file == ddfd_register_file_type'($past(src1_fcode)))
    else $error("source1 file wrong");

  a_src0_fields: assert property (
    take && src0_fcode == 2'h1 |=> source0_register_file == RF_GENERAL
      && source0_numeric_type == ddfd_numeric_type_type'({1'h0, $past(src0_code)}))
    else $error("source0 fields wrong");

  a_dest_double: assert property (
    take && dst_code == 3'h6 |=> dest_numeric_type == NT_DOUBLE)
    else $error("destination double type wrong");

  a_dest_file_bad: assert property (
    take && dst_fcode[1] |=> decode_illegal && dest_register_file == RF_RESERVED)
    else $error("reserved destination file not flagged");

  a_a16_direct_fields: assert property (
    take && sixteen_byte_aligned_operands && !region[15] |=> dest_register_number == $past(instr_dword1[28:21])
      && dest_channel_write_enables == $past(instr_dword1[19:16]))
    else $error("direct sixteen-byte fields wrong");

  a_a1_direct_fields: assert property (
    take && !sixteen_byte_aligned_operands && !region[15] |=> dest_horizontal_stride == $past(instr_dword1[30:29])
      && dest_subregister_number == $past(instr_dword1[20:16]))
    else $error("direct byte-aligned fields wrong");

  a_a16_indirect_off: assert property (
    take && sixteen_byte_aligned_operands && region[15] |=> dest_immediate_offset[9:4] == $past(instr_dword1[25:20])
      && dest_address_subregister == $past(instr_dword1[28:26]))
    else $error("indirect sixteen-byte fields wrong");

  a_send_cur_direct: assert property (
    take && instr_is_send |=> !current_destination_addressing && dest_addressing_select == $past(region[15]))
    else $error("send current destination not direct");

  a_layout_pick: assert property (
    take |=> dest_layout == ddfd_layout_type'({$past(region[15]), !$past(sixteen_byte_aligned_operands)}))
    else $error("layout select wrong");

  a_illegal_sticky: assert property (
    decode_valid && decode_illegal |-> s.illegal_seen ##1 (s.illegal_seen || wr_fire || $past(wr_fire)))
    else $error("illegal flag not sticky");

  c_send_decode:  cover property (take && instr_is_send ##1 decode_valid);
  c_illegal_seen: cover property (decode_valid && decode_illegal);
  c_status_read:  cover property (s_axi_rvalid && s_axi_rready && s.illegal_seen);

endmodule // ddfd_top

// File: sim/ddfd_fetch_model.sv
`timescale 1ns/1ps
// ==========
// fetch stage model
module ddfd_fetch_model (
  input  wire logic        aclk,
  input  wire logic        go,
  input  wire logic        a16,
  input  wire logic        snd,
  input  wire logic [31:0] d1,
  output logic             instr_valid,
  output logic [31:0]      instr_dword0,
  output logic [31:0]      instr_dword1,
  output logic             instr_is_send
);
  initial {instr_valid, instr_dword0, instr_dword1, instr_is_send} = '0;
  always @(posedge aclk) begin
    instr_valid <= go;
    if (go) begin
      {instr_dword0, instr_dword1, instr_is_send} <= {23'h0, a16, 8'h0, d1 | {2'h0, a16, 29'h0}, snd};
    end else begin
      {instr_dword0, instr_dword1} <= ~{instr_dword0, instr_dword1};
    end
  end
endmodule // ddfd_fetch_model

// File: sim/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin miscompares++; $display("BAD %s exp %h got %h", n, e, a); end end
// ==========
// decoder bench
module tb
  import ddfd_pkg::*;
;
  logic        aclk, aresetn, awv, wv, brdy, arv, rrdy, go, a16, snd;
  logic [7:0]  awa, ara;
  logic [31:0] wd, d1, rv;
  logic [53:0] keep;
  int          checks, miscompares;
  wire         awr, wrd, bv, arr, rvl, iv, isnd, dv, ill;
  wire [1:0]   br, rr;
  wire [31:0]  rdat, dw0, dw1;
  wire [53:0]  got;
  logic [34:0] rows [9] = '{{2'h2, 32'h1ab50425, 1'h0}, {2'h1, 32'h7fff0425, 1'h0}, {2'h3, 32'h9c3a0425, 1'h0},
    {2'h0, 32'h80000425, 1'h0}, {2'h2, 32'h1ab50825, 1'h1}, {2'h2, 32'h1ab58425, 1'h1},
    {2'h2, 32'h5ab50425, 1'h1}, {2'h0, 32'h1ab50427, 1'h1}, {2'h0, 32'h1ab50445, 1'h1}};
  ddfd_fetch_model i_src (.aclk(aclk), .go(go), .a16(a16), .snd(snd), .d1(d1), .instr_valid(iv),
    .instr_dword0(dw0), .instr_dword1(dw1), .instr_is_send(isnd));
  ddfd_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rvl), .s_axi_rready(rrdy), .instr_valid(iv), .instr_dword0(dw0), .instr_dword1(dw1),
    .instr_is_send(isnd), .decode_valid(dv), .source1_numeric_type(got[53:50]),
    .source1_register_file(got[49:48]), .source0_numeric_type(got[47:44]), .source0_register_file(got[43:42]),
    .dest_numeric_type(got[41:38]), .dest_register_file(got[37:36]), .dest_layout(got[35:34]),
    .current_destination_addressing(got[33]), .dest_addressing_select(got[32]), .dest_register_number(got[31:24]),
    .dest_subregister_number(got[23:19]), .dest_channel_write_enables(got[18:15]),
    .dest_horizontal_stride(got[14:13]), .dest_address_subregister(got[12:10]), .dest_immediate_offset(got[9:0]),
    .decode_illegal(ill));
  // ==========
  // expected fields
  function automatic logic [3:0] ty(input logic [2:0] c, input logic m);
    return {1'b0, c} + ((m && c[2] && c != 3'h7) ? 4'h4 : 4'h0);
  endfunction
  function automatic logic [53:0] expd(input logic a, input logic s, input logic [31:0] d);
    logic [15:0] r;
    logic        x;
    r = d[31:16];
    x = a & r[15];
    return {ty(d[14:12], d[11:10] == 2'h3), d[11:10], ty(d[9:7], d[6:5] == 2'h3), d[6:5], ty(d[4:2], 1'b0),
      (d[1:0] == 2'h3) ? 2'h2 : d[1:0], r[15], ~a, r[15] & ~s, r[15], r[15] ? 8'h0 : r[12:5],
      r[15] ? 5'h0 : (a ? {r[4], 4'h0} : r[4:0]), a ? r[3:0] : 4'hf, a ? 2'h0 : r[14:13],
      x ? r[12:10] : 3'h0, x ? {r[9:4], 4'h0} : 10'h0};
  endfunction
  // ==========
  // drivers
  task automatic issue(input logic a, input logic s, input logic [31:0] d, input logic il);
    @(posedge aclk);
    {go, a16, snd, d1} <= {1'b1, a, s, d};
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    #1;
    `CHK("valid", 1'b1, dv)
    `CHK("fields", expd(a, s, d), got)
    `CHK("illegal", il, ill)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    {awa, wd, awv, wv, brdy} <= {a, d, 3'h7};
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    brdy <= 1'b0;
    `CHK("bresp", e, br)
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] e);
    @(posedge aclk);
    {ara, arv, rrdy} <= {a, 2'h3};
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rvl);
    rrdy <= 1'b0;
    rv = rdat;
    `CHK("rresp", e, rr)
  endtask
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    final_report;
  end
  initial begin
    {aresetn, awv, wv, brdy, arv, rrdy, go, a16, snd, awa, ara, wd, d1} = '0;
    repeat (12) @(posedge aclk);
    `CHK("reset", 55'h0, {dv, got})
    aresetn <= 1'b1;
    rd(ADDR_CTRL, RESP_OKAY);
    `CHK("ctrl", 32'h1, rv)
    foreach (rows[k]) issue(rows[k][34], rows[k][33], rows[k][32:1], rows[k][0]);
    $display("layout rows done");
    for (int c = 0; c < 16; c++) begin
      issue(1'b0, 1'b0, {16'h1ab5, 1'b0, c[2:0], c[3] ? 2'h3 : 2'h1, c[3] ? 3'h3 : c[2:0], 2'h1, c[2:0], 2'h1}, 1'b0);
    end
    $display("type codes done");
    rd(ADDR_STATUS, RESP_OKAY);
    `CHK("status", {16'h19, 1'b1}, {rv[31:16], rv[0]})
    rd(ADDR_LAST_ILLEGAL, RESP_OKAY);
    `CHK("last", 32'h1ab50445, rv)
    wr(ADDR_STATUS, 32'h1, RESP_OKAY);
    rd(ADDR_STATUS, RESP_OKAY);
    `CHK("clear", 1'b0, rv[0])
    wr(8'h0c, 32'h1, RESP_SLVERR);
    rd(8'h0c, RESP_SLVERR);
    `CHK("unmapped", 32'h0, rv)
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    keep = got;
    @(posedge aclk);
    {go, a16, snd, d1} <= {3'h6, 32'h1ab50425};
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    #1;
    `CHK("held", {1'b0, keep}, {dv, got})
    `CHK("held illegal", 1'b0, ill)
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    $display("registers done");
    @(posedge aclk);
    {go, a16, snd, d1} <= {3'h6, 32'h1ab50425};
    @(posedge aclk);
    d1 <= 32'h9c3a0425;
    @(posedge aclk);
    go <= 1'b0;
    #1;
    `CHK("first", expd(1'b1, 1'b0, 32'h1ab50425), got)
    @(posedge aclk);
    #1;
    `CHK("second", {1'b1, expd(1'b1, 1'b0, 32'h9c3a0425)}, {dv, got})
    @(posedge aclk);
    #1;
    `CHK("pulse", 1'b0, dv)
    $display("back to back done");
    final_report;
  end
endmodule // tb
